// file: shared/pmrm_pkg.sv
/*
  Shared constants and types for the receive data pins and management pins.
  Assumes a 20 MHz system clock on both ends of the link.
*/
package pmrm_pkg;

  // ----------------------------------------------------------------------
  // Modes of the receive data pins
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PMRM_MII, PMRM_RMII, PMRM_RGMII} pmrm_mode_e;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_NS = 50;
  localparam int MII_CLK_NS = 400;
  localparam int RMII_CLK_NS = 200;
  localparam int MDC_MAX_KHZ = 1750;
  localparam int NS_KHZ = 1000000;
  localparam logic [3:0] MII_HALF = 4'(MII_CLK_NS / (2 * SYS_CLK_NS));
  localparam logic [3:0] RMII_HALF = 4'(RMII_CLK_NS / (2 * SYS_CLK_NS));
  localparam logic [3:0] MDC_HALF = 4'((NS_KHZ + 2 * SYS_CLK_NS * MDC_MAX_KHZ - 1)
                                       / (2 * SYS_CLK_NS * MDC_MAX_KHZ));

  // ----------------------------------------------------------------------
  // Management frame
  // ----------------------------------------------------------------------
  localparam logic [1:0] MDIO_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [5:0] PRE_BITS = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0B;
  localparam logic [5:0] DAT_LAST = 6'h0F;
  localparam logic [5:0] TA_SECOND = 6'h01;
  localparam logic [6:0] PRE_IDX = 7'h20;
  localparam logic [6:0] TA_IDX = 7'h2E;
  localparam logic [6:0] DAT_IDX = 7'h30;
  localparam logic [6:0] FRAME_BITS = 7'h40;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] pa;
    logic [4:0] ra;
  } pmrm_hdr_s;

  typedef struct packed {
    logic [1:0] st;
    logic [1:0] op;
    logic [4:0] pa;
    logic [4:0] ra;
    logic [1:0] ta;
    logic [15:0] data;
  } pmrm_frame_s;

  // ----------------------------------------------------------------------
  // Symbol buffer
  // ----------------------------------------------------------------------
  localparam int SYM_W = 5;
  localparam int FIFO_DEPTH = 4;

endpackage

// file: shared/pmrm_if.sv
/*
  Pins between the device end and the MAC end.
  Assumes nothing; the data line resolves with a pull-up when nobody drives.
*/
`timescale 1ns/10ps
interface pmrm_if;
  logic rx_clk;
  logic [3:0] rx_d;
  logic rx_dv;
  logic rx_er;
  logic mdc;
  logic mdio_sta_o;
  logic mdio_sta_oe;
  logic mdio_phy_o;
  logic mdio_phy_oe;
  logic mdio_line;

  // The station wins a clash; an undriven line reads high.
  assign mdio_line = mdio_sta_oe ? mdio_sta_o : (mdio_phy_oe ? mdio_phy_o : 1'b1);

  modport phy (
    output rx_clk, rx_d, rx_dv, rx_er, mdio_phy_o, mdio_phy_oe,
    input mdc, mdio_line
  );
  modport mac (
    input rx_clk, rx_d, rx_dv, rx_er, mdio_line,
    output mdc, mdio_sta_o, mdio_sta_oe
  );
endinterface

// file: hdl/pmrm_phy_end.sv
/*
  Device end: symbol buffer, receive clock and data pins, management slave.
  Assumes sys_clk at 20 MHz and a station clocking the management pins slowly.
*/
`timescale 1ns/10ps

// ------------------------------------------------------------------------
// Symbol buffer
// ------------------------------------------------------------------------
module pmrm_fifo #(
  parameter int W = 5,
  parameter int D = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } pmrm_fifo_s;

  pmrm_fifo_s r;
  pmrm_fifo_s n;
  logic full;
  logic empty;

  assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
  assign empty = (r.wp == r.rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = r.mem[r.rp[AW-1:0]];

  always_comb begin
    n = r;
    if (in_valid && !full) begin
      n.mem[r.wp[AW-1:0]] = in_data;
      n.wp = r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      n.rp = r.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // pmrm_fifo

// ------------------------------------------------------------------------
// Device end
// ------------------------------------------------------------------------
// Contract
// R1 - Station keeps management clock at most 1.75 MHz
// R2 - Management clock may be unrelated to receive clock
// R3 - Shared data line, driver chosen by frame phase
// R4 - Receive data changes on receive clock rising edge
// R5 - Data meaningful only while data valid high
// R6 - Four bits per clock MII, two RMII
// R7 - RMII valid pin merges carrier and valid
// R8 - Repeater option gives pure data valid
// R9 - RGMII control: valid rising, error falling
// R10 - System gives 25 MHz reference, MII/RMII master; the code takes no reference and divides rx_clk from the 20 MHz sys_clk
// R11 - System gives 50 MHz reference, RMII slave; the code has no slave mode, the device end always drives rx_clk
// R12 - Error pin high on error symbol, rising aligned
// R13 - RGMII 10 Mbps receive clock is 2.5 MHz
// R14 - RMII master drives reference clock on clock pin
module pmrm_phy_end import pmrm_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pmrm_mode_e mode,
  input wire logic repeater_en,
  input wire logic carrier,
  input wire logic sym_valid,
  output logic sym_ready,
  input wire logic [3:0] sym_data,
  input wire logic sym_err,
  input wire logic [4:0] phy_addr,
  output logic mg_rd_stb,
  output logic mg_wr_stb,
  output logic [4:0] mg_reg,
  output logic [15:0] mg_wdata,
  input wire logic [15:0] mg_rdata,
  pmrm_if.phy lnk
);

  typedef enum {MG_PRE, MG_START, MG_HDR, MG_TA, MG_DAT} pmrm_mg_e;

  typedef struct packed {
    logic [3:0] div;
    logic clk;
    logic half;
    logic [1:0] hi;
    logic [3:0] d;
    logic dv;
    logic er;
    logic pin;
    logic mdc1;
    logic mdc2;
    logic mdc3;
    logic mio1;
    logic mio2;
    pmrm_mg_e st;
    logic [5:0] cnt;
    pmrm_hdr_s hdr;
    logic [15:0] sh;
    logic rd;
    logic wr;
    logic o;
    logic oe;
    logic rstb;
    logic wstb;
  } pmrm_phy_s;

  pmrm_phy_s r;
  pmrm_phy_s n;
  logic [SYM_W-1:0] f_data;
  logic f_valid;
  logic pop;
  logic tick;
  logic rise;
  logic edge_mdc;
  logic bit_in;
  logic [3:0] half_cyc;
  pmrm_hdr_s hdr_nxt;

  // ----------------------------------------------------------------------
  // Symbol buffer; a full buffer stalls the symbol source
  // ----------------------------------------------------------------------
  pmrm_fifo #(
    .W(SYM_W),
    .D(FIFO_DEPTH)
  ) pmrm_fifo_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(sym_valid),
    .in_ready(sym_ready),
    .in_data({sym_err, sym_data}),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign lnk.rx_clk = r.clk;
  assign lnk.rx_d = r.d;
  assign lnk.rx_dv = r.pin;
  assign lnk.rx_er = r.er;
  assign lnk.mdio_phy_o = r.o;
  assign lnk.mdio_phy_oe = r.oe;
  assign mg_rd_stb = r.rstb;
  assign mg_wr_stb = r.wstb;
  assign mg_reg = r.hdr.ra;
  assign mg_wdata = r.sh;

  // ----------------------------------------------------------------------
  // Receive clock and data
  // ----------------------------------------------------------------------
  assign half_cyc = (mode == PMRM_RMII) ? RMII_HALF : MII_HALF; // R13 R14
  assign tick = (r.div == half_cyc - 4'h1);
  assign rise = tick && !r.clk;
  assign pop = rise && ((mode != PMRM_RMII) || !r.half);
  assign edge_mdc = r.mdc2 && !r.mdc3;
  assign bit_in = r.mio2;
  assign hdr_nxt = pmrm_hdr_s'({r.hdr[10:0], bit_in});

  always_comb begin
    n = r;
    n.rstb = 1'b0;
    n.wstb = 1'b0;
    n.div = tick ? 4'h0 : r.div + 4'h1;
    n.clk = tick ? !r.clk : r.clk; // R13 R14
    if (rise) begin
      if (mode == PMRM_RMII && r.half) begin
        n.d = {2'h0, r.hi}; // R6
        n.half = 1'b0;
      end else begin
        n.dv = f_valid; // R5
        n.er = f_valid && f_data[SYM_W-1]; // R12
        n.hi = f_data[3:2];
        n.half = (mode == PMRM_RMII) && f_valid;
        if (!f_valid) begin
          n.d = 4'h0;
        end else if (mode == PMRM_RMII) begin
          n.d = {2'h0, f_data[1:0]}; // R6
        end else begin
          n.d = f_data[3:0]; // R4 R6
        end
      end
      case (mode)
        PMRM_RMII: n.pin = repeater_en ? n.dv : (n.dv || carrier); // R7 R8
        default: n.pin = n.dv; // R4 R9
      endcase
    end else if (tick && r.clk && mode == PMRM_RGMII) begin
      n.pin = r.er; // R9
    end

    // --------------------------------------------------------------------
    // Management slave, sampled on management clock rising edges
    // --------------------------------------------------------------------
    n.mdc1 = lnk.mdc; // R2
    n.mdc2 = r.mdc1;
    n.mdc3 = r.mdc2;
    n.mio1 = lnk.mdio_line;
    n.mio2 = r.mio1;
    if (edge_mdc) begin
      case (r.st)
        MG_PRE: begin
          if (bit_in) begin
            n.cnt = (r.cnt == PRE_BITS) ? r.cnt : r.cnt + 6'h01;
          end else if (r.cnt == PRE_BITS) begin
            n.st = MG_START;
          end else begin
            n.cnt = '0;
          end
        end
        MG_START: begin
          n.cnt = '0;
          n.st = bit_in ? MG_HDR : MG_PRE;
        end
        MG_HDR: begin
          n.hdr = hdr_nxt;
          n.cnt = r.cnt + 6'h01;
          if (r.cnt == HDR_LAST) begin
            n.st = MG_TA;
            n.cnt = '0;
            n.rd = (hdr_nxt.op == OP_READ) && (hdr_nxt.pa == phy_addr);
            n.wr = (hdr_nxt.op == OP_WRITE) && (hdr_nxt.pa == phy_addr);
            n.rstb = n.rd;
          end
        end
        MG_TA: begin
          if (r.cnt != TA_SECOND) begin
            n.cnt = TA_SECOND;
            if (r.rd) begin
              n.oe = 1'b1; // R3
              n.o = 1'b0;
              n.sh = mg_rdata;
            end
          end else begin
            n.st = MG_DAT;
            n.cnt = '0;
            if (r.rd) begin
              n.o = r.sh[15]; // R3
              n.sh = {r.sh[14:0], 1'b0};
            end
          end
        end
        MG_DAT: begin
          if (r.wr) begin
            n.sh = {r.sh[14:0], bit_in}; // R3
          end
          if (r.cnt == DAT_LAST) begin
            n.st = MG_PRE;
            n.cnt = '0;
            n.oe = 1'b0; // R3
            n.wstb = r.wr;
            n.rd = 1'b0;
          end else begin
            n.cnt = r.cnt + 6'h01;
            if (r.rd) begin
              n.o = r.sh[15];
              n.sh = {r.sh[14:0], 1'b0};
            end
          end
        end
        default: begin
          n.st = MG_PRE;
          n.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // pmrm_phy_end

// file: hdl/pmrm_mac_end.sv
/*
  MAC end: management station and receive pin sampler.
  Assumes sys_clk at 20 MHz; receive pins come from another clock domain.
*/
`timescale 1ns/10ps
module pmrm_mac_end import pmrm_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pmrm_mode_e mode,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [4:0] cmd_phy,
  input wire logic [4:0] cmd_reg,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_done,
  output logic [15:0] rsp_rdata,
  output logic nib_valid,
  output logic [3:0] nib_data,
  output logic nib_err,
  pmrm_if.mac lnk
);

  typedef struct packed {
    logic c1;
    logic c2;
    logic c3;
    logic [3:0] d1;
    logic [3:0] d2;
    logic v1;
    logic v2;
    logic e1;
    logic e2;
    logic [3:0] dat;
    logic dvh;
    logic [1:0] lo;
    logic eh;
    logic pair;
    logic nv;
    logic [3:0] nd;
    logic ne;
    logic m1;
    logic m2;
    logic [3:0] div;
    logic mdc;
    logic busy;
    logic [6:0] idx;
    pmrm_frame_s frame;
    logic isrd;
    logic o;
    logic oe;
    logic [15:0] rdata;
    logic done;
  } pmrm_mac_s;

  pmrm_mac_s r;
  pmrm_mac_s n;
  logic rise;
  logic fall;

  assign cmd_ready = !r.busy;
  assign rsp_done = r.done;
  assign rsp_rdata = r.rdata;
  assign nib_valid = r.nv;
  assign nib_data = r.nd;
  assign nib_err = r.ne;
  assign lnk.mdc = r.mdc;
  assign lnk.mdio_sta_o = r.o;
  assign lnk.mdio_sta_oe = r.oe;
  assign rise = r.c2 && !r.c3;
  assign fall = !r.c2 && r.c3;

  always_comb begin
    n = r;
    n.nv = 1'b0;
    n.done = 1'b0;
    // --------------------------------------------------------------------
    // Receive pin sampler
    // --------------------------------------------------------------------
    n.c1 = lnk.rx_clk;
    n.c2 = r.c1;
    n.c3 = r.c2;
    n.d1 = lnk.rx_d;
    n.d2 = r.d1;
    n.v1 = lnk.rx_dv;
    n.v2 = r.v1;
    n.e1 = lnk.rx_er;
    n.e2 = r.e1;
    case (mode)
      PMRM_RMII: begin
        if (rise) begin
          if (!r.v2) begin
            n.pair = 1'b0; // R5
          end else if (r.pair) begin
            n.nv = 1'b1;
            n.nd = {r.d2[1:0], r.lo};
            n.ne = r.eh || r.e2;
            n.pair = 1'b0;
          end else begin
            n.lo = r.d2[1:0];
            n.eh = r.e2;
            n.pair = 1'b1;
          end
        end
      end
      PMRM_RGMII: begin
        if (rise) begin
          n.dat = r.d2;
          n.dvh = r.v2; // R9
        end else if (fall && r.dvh) begin
          n.nv = 1'b1;
          n.nd = r.dat;
          n.ne = r.v2; // R9
        end
      end
      default: begin
        if (rise && r.v2) begin
          n.nv = 1'b1; // R5
          n.nd = r.d2;
          n.ne = r.e2;
        end
      end
    endcase

    // --------------------------------------------------------------------
    // Management station
    // --------------------------------------------------------------------
    n.m1 = lnk.mdio_line;
    n.m2 = r.m1;
    if (!r.busy) begin
      if (cmd_valid) begin
        n.busy = 1'b1;
        n.idx = '0;
        n.div = '0;
        n.isrd = cmd_read;
        n.frame.st = MDIO_START;
        n.frame.op = cmd_read ? OP_READ : OP_WRITE;
        n.frame.pa = cmd_phy;
        n.frame.ra = cmd_reg;
        n.frame.ta = TA_WRITE;
        n.frame.data = cmd_read ? 16'h0000 : cmd_wdata;
        n.o = 1'b1;
        n.oe = 1'b1; // R3
      end
    end else if (r.div == MDC_HALF - 4'h1) begin
      n.div = '0;
      n.mdc = !r.mdc; // R1
      if (!r.mdc) begin
        if (r.isrd && r.idx >= DAT_IDX) begin
          n.rdata = {r.rdata[14:0], r.m2}; // R3
        end
        n.idx = r.idx + 7'h01;
      end else if (r.idx == FRAME_BITS) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.oe = 1'b0;
      end else begin
        n.o = (r.idx < PRE_IDX) ? 1'b1 : r.frame[~r.idx[4:0]];
        n.oe = !(r.isrd && r.idx >= TA_IDX); // R3
      end
    end else begin
      n.div = r.div + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // pmrm_mac_end

// file: bench/pmrm_assertions.sv
/*
  Concurrent checks on the pins between the device end and the MAC end.
  Assumes one sys_clk domain and mode changes only while rst is high.
*/
`timescale 1ns/10ps
module pmrm_assertions import pmrm_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pmrm_mode_e mode,
  input wire logic repeater_en,
  input wire logic carrier,
  input wire logic rx_clk,
  input wire logic [3:0] rx_d,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic mdc,
  input wire logic mdio_sta_oe,
  input wire logic mdio_phy_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_mdc_high_min: assert property ($rose(mdc) |=> mdc [*5])
    else $error("management clock high phase too short");
  a_mdc_low_min: assert property ($fell(mdc) |=> !mdc [*5])
    else $error("management clock low phase too short");
  a_mdio_one_driver: assert property (!(mdio_sta_oe && mdio_phy_oe))
    else $error("both ends drive the management data line");
  a_rx_d_rise: assert property ($changed(rx_d) |-> $rose(rx_clk))
    else $error("receive data changed away from a rising receive clock");
  a_mii_dv_rise: assert property (mode != PMRM_RGMII && $changed(rx_dv) |-> $rose(rx_clk))
    else $error("data valid changed away from a rising receive clock");
  a_rmii_upper_zero: assert property (mode == PMRM_RMII |-> rx_d[3:2] == 2'h0)
    else $error("upper receive data bits driven in two bit mode");
  a_rmii_combined_dv: assert property (mode == PMRM_RMII && !repeater_en
    && $past(carrier) && $rose(rx_clk) |-> rx_dv)
    else $error("combined valid low while carrier present");
  a_rgmii_ctrl_edge: assert property (mode == PMRM_RGMII && $changed(rx_dv)
    |-> $changed(rx_clk))
    else $error("receive control changed away from a receive clock edge");
  a_mii_er_rise: assert property (mode != PMRM_RGMII && $changed(rx_er) |-> $rose(rx_clk))
    else $error("receive error changed away from a rising receive clock");
  a_rgmii_clk_high: assert property (mode == PMRM_RGMII && $rose(rx_clk)
    |=> rx_clk [*3] ##1 !rx_clk)
    else $error("receive clock high phase wrong in four bit control mode");

  c_rmii_valid: cover property (mode == PMRM_RMII && rx_dv && $rose(rx_clk));
  c_phy_drives: cover property ($rose(mdio_phy_oe));
  c_rx_error: cover property ($rose(rx_er));
endmodule // pmrm_assertions

// file: bench/pmrm_test.sv
/*
  Self-checking bench joining the device end and the MAC end.
  Assumes the shared package and interface; runs on a 20 MHz sys_clk.
*/
`timescale 1ns/10ps
module pmrm_test;
  import pmrm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  pmrm_mode_e mode = PMRM_MII;
  logic repeater_en = 1'b0, carrier = 1'b0, sym_valid = 1'b0, sym_err = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0;
  logic [3:0] sym_data = 4'h0;
  logic [4:0] phy_addr = 5'h0A, cmd_phy = 5'h00, cmd_reg = 5'h00;
  logic [15:0] mg_rdata = 16'hC35A, cmd_wdata = 16'h0000;
  logic sym_ready, mg_rd_stb, mg_wr_stb, cmd_ready, rsp_done, nib_valid, nib_err, stalled;
  logic [4:0] mg_reg, seen_reg;
  logic [15:0] mg_wdata, rsp_rdata, seen_wdata;
  logic [3:0] nib_data;
  logic [4:0] got_q[$];
  int errors = 0, n_tests = 0, wr_seen = 0, rd_seen = 0;

  pmrm_if lnk ();
  pmrm_phy_end pmrm_phy_end_inst (.sys_clk, .rst, .mode, .repeater_en, .carrier, .sym_valid,
    .sym_ready, .sym_data, .sym_err, .phy_addr, .mg_rd_stb, .mg_wr_stb, .mg_reg, .mg_wdata,
    .mg_rdata, .lnk(lnk));
  pmrm_mac_end pmrm_mac_end_inst (.sys_clk, .rst, .mode, .cmd_valid, .cmd_ready, .cmd_read,
    .cmd_phy, .cmd_reg, .cmd_wdata, .rsp_done, .rsp_rdata, .nib_valid, .nib_data, .nib_err,
    .lnk(lnk));
  pmrm_assertions pmrm_assertions_inst (.sys_clk, .rst, .mode, .repeater_en, .carrier,
    .rx_clk(lnk.rx_clk), .rx_d(lnk.rx_d), .rx_dv(lnk.rx_dv), .rx_er(lnk.rx_er), .mdc(lnk.mdc),
    .mdio_sta_oe(lnk.mdio_sta_oe), .mdio_phy_oe(lnk.mdio_phy_oe));

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------------
  // Capture of what the user sides deliver
  // ----------------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (nib_valid === 1'b1) begin
      got_q.push_back({nib_err, nib_data});
    end
    if (mg_wr_stb === 1'b1) begin
      wr_seen++;
      seen_reg = mg_reg;
      seen_wdata = mg_wdata;
    end
    if (mg_rd_stb === 1'b1) begin
      rd_seen++;
      seen_reg = mg_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_hi(ref logic sig, input int lim);
    int k;
    k = 0;
    while (sig !== 1'b1 && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    if (sig !== 1'b1) begin
      check("wait bound", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  task automatic do_reset(input pmrm_mode_e m);
    @(negedge sys_clk);
    rst = 1'b1;
    mode = m;
    repeater_en = 1'b0;
    carrier = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    got_q.delete();
  endtask

  task automatic send_sym(input logic [3:0] d, input logic e);
    sym_valid = 1'b1;
    sym_data = d;
    sym_err = e;
    if (sym_ready !== 1'b1) begin
      stalled = 1'b1;
    end
    wait_hi(sym_ready, 200);
    @(negedge sys_clk);
  endtask

  task automatic mgmt(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd);
    int k;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_phy = pa;
    cmd_reg = ra;
    cmd_wdata = wd;
    wait_hi(cmd_ready, 100);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_done !== 1'b1 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    check("frame length", 32'(k >= 768 && k < 2000), 32'h1);
    if (k == 2000) begin
      report_and_stop();
    end
    repeat (10) @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic stream_case(input pmrm_mode_e m);
    do_reset(m);
    stalled = 1'b0;
    for (int i = 0; i < 6; i++) begin
      send_sym(4'(i * 3 + 1), i == 2);
    end
    sym_valid = 1'b0;
    sym_err = 1'b0;
    for (int k = 0; k < 400 && got_q.size() < 6; k++) begin
      @(negedge sys_clk);
    end
    repeat (40) @(negedge sys_clk);
    check("nibble count", 32'(got_q.size()), 32'h6);
    if (got_q.size() < 6) begin
      report_and_stop();
    end
    for (int i = 0; i < 6 && i < got_q.size(); i++) begin
      check("nibble", 32'(got_q[i]), 32'({i == 2, 4'(i * 3 + 1)}));
    end
    check("buffer stall", 32'(stalled), 32'h1);
  endtask

  task automatic carrier_case();
    do_reset(PMRM_RMII);
    check("idle mdio", 32'(lnk.mdio_line), 32'h1);
    check("idle mdc", 32'(lnk.mdc), 32'h0);
    carrier = 1'b1;
    repeat (20) @(negedge sys_clk);
    check("combined valid", 32'(lnk.rx_dv), 32'h1);
    repeater_en = 1'b1;
    repeat (20) @(negedge sys_clk);
    check("pure valid", 32'(lnk.rx_dv), 32'h0);
  endtask

  task automatic mgmt_case();
    do_reset(PMRM_MII);
    mgmt(1'b0, 5'h0A, 5'h03, 16'hA55C);
    check("write strobes", 32'(wr_seen), 32'h1);
    check("write reg", 32'(seen_reg), 32'h3);
    check("write data", 32'(seen_wdata), 32'hA55C);
    mgmt(1'b1, 5'h0A, 5'h1F, 16'h0000);
    check("read strobes", 32'(rd_seen), 32'h1);
    check("read reg", 32'(seen_reg), 32'h1F);
    check("read data", 32'(rsp_rdata), 32'hC35A);
    mgmt(1'b0, 5'h0B, 5'h04, 16'h1234);
    check("foreign write", 32'(wr_seen), 32'h1);
  endtask

  initial begin
    stream_case(PMRM_MII);
    stream_case(PMRM_RMII);
    stream_case(PMRM_RGMII);
    carrier_case();
    mgmt_case();
    report_and_stop();
  end
endmodule // pmrm_test
